// *** rtl/dpraa_pkg.sv ***
// Package with shared types and constants for the dual-port memory host controller.
`default_nettype none

package dpraa_pkg;

   // ==========================================================================
   // Widths
   localparam int ADDR_W = 14;
   localparam int DATA_W = 16;
   localparam int CNT_W  = 4;

   // ==========================================================================
   // Timing, in nanoseconds as printed, and derived cycle counts
   localparam int CLK_PERIOD_NS = 8;
   localparam int T_PWE_NS      = 20;
   localparam int T_ACCESS_NS   = 25;
   localparam int T_SOP_NS      = 12;
   localparam int SYNC_STAGES   = 2;

   // Least times round up to whole cycles.
   localparam logic [CNT_W-1:0] PWE_CYC    = CNT_W'((T_PWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] ACCESS_CYC = CNT_W'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] SOP_CYC    = CNT_W'((T_SOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // Read data pass the pin synchroniser, so the wait covers its stages too.
   localparam logic [CNT_W-1:0] READ_CYC   = CNT_W'(ACCESS_CYC + CNT_W'(SYNC_STAGES));
   localparam logic [CNT_W-1:0] CNT_ONE    = CNT_W'(1);
   localparam logic [CNT_W-1:0] CNT_ZERO   = '0;

   // ==========================================================================
   // Field positions and levels
   localparam int   SEM_BIT  = 0;
   localparam logic LEVEL_HI = 1'h1;
   localparam logic LEVEL_LO = 1'h0;

   // ==========================================================================
   // Types
   typedef enum logic [1:0] {
      DPRAA_OP_MEM_READ,
      DPRAA_OP_MEM_WRITE,
      DPRAA_OP_SEM_READ,
      DPRAA_OP_SEM_WRITE
   } dpraa_op_type;

   typedef struct packed {
      dpraa_op_type        op;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wdata;
      logic                upper_lane_select_n;
      logic                lower_lane_select_n;
   } dpraa_cmd_type;

   typedef struct packed {
      logic                port_select_n;
      logic                semaphore_select_n;
      logic                upper_lane_select_n;
      logic                lower_lane_select_n;
      logic                write_n;
      logic                output_enable_n;
      logic [ADDR_W-1:0]   addr;
   } dpraa_pins_type;

   localparam dpraa_pins_type PINS_IDLE = '{
      port_select_n:       1'h1,
      semaphore_select_n:  1'h1,
      upper_lane_select_n: 1'h1,
      lower_lane_select_n: 1'h1,
      write_n:             1'h1,
      output_enable_n:     1'h1,
      addr:                '0
   };

endpackage : dpraa_pkg

`default_nettype wire

// *** rtl/dpraa_sync.sv ***
// Two-flop synchroniser for the device pins read by the host controller.
`default_nettype none

module dpraa_sync #(
   parameter int               WIDTH       = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input  wire logic             i_ref_clk,
   input  wire logic             i_arst_n,
   input  wire logic [WIDTH-1:0] i_d,
   output var  logic [WIDTH-1:0] o_q
);

   logic [WIDTH-1:0] meta;

   // ==========================================================================
   // Synchroniser stages
   // The first stage feeds only the second, so no logic sees a metastable value.
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         meta <= RESET_VALUE;
         o_q  <= RESET_VALUE;
      end else begin
         meta <= i_d;
         o_q  <= meta;
      end
   end

endmodule : dpraa_sync

`default_nettype wire

// *** rtl/dpraa_host.sv ***
// Host controller that drives one port of an asynchronous dual-port memory.
`default_nettype none

// Overview of operation
// - Write strobe stays high throughout every read cycle.
// - Write strobe is high whenever the address pins change.
// - Data are written only while a select and a lane select overlap low strobe.
// - Memory access: port select low, semaphore select high, lane selects per byte.
// - Port select stays high across semaphore write and read-back.
// - Semaphore request writes data bit zero low with semaphore select active.
// - Slave role only: busy from the device gates writes; no busy output is driven.
// - Semaphore access holds port select high and semaphore select low.
// - Once busy is seen the host returns the write strobe high.
module dpraa_host (
   input  wire logic                    i_ref_clk,
   input  wire logic                    i_arst_n,
   input  wire logic                    i_cmd_valid,
   input  wire dpraa_pkg::dpraa_cmd_type i_cmd,
   output var  logic                    o_cmd_ready,
   output var  logic                    o_rsp_valid,
   output var  logic [15:0]             o_rsp_data,
   output var  dpraa_pkg::dpraa_pins_type o_pins,
   input  wire logic [15:0]             i_data,
   output var  logic [15:0]             o_data,
   output var  logic                    o_data_oe,
   input  wire logic                    i_busy_n
);
   import dpraa_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SETUP,
      ST_STROBE,
      ST_RELEASE,
      ST_READ_WAIT,
      ST_RECOVER
   } dpraa_state_type;

   dpraa_state_type   state;
   dpraa_state_type   next_state;
   logic [CNT_W-1:0]  cnt;
   logic [CNT_W-1:0]  next_cnt;
   dpraa_cmd_type     cmd;
   dpraa_pins_type    next_pins;
   dpraa_pins_type    setup_pins;
   logic [DATA_W:0]   sync_q;
   logic              busy_n_s;
   logic [DATA_W-1:0] rdata_s;

   // ==========================================================================
   // Pin inputs
   dpraa_sync #(
      .WIDTH       (DATA_W + 1),
      .RESET_VALUE ({LEVEL_HI, {DATA_W{LEVEL_LO}}})
   ) u_sync (
      .i_ref_clk (i_ref_clk),
      .i_arst_n  (i_arst_n),
      .i_d       ({i_busy_n, i_data}),
      .o_q       (sync_q)
   );

   assign busy_n_s = sync_q[DATA_W];
   assign rdata_s  = sync_q[DATA_W-1:0];

   // ==========================================================================
   // Decode
   wire take      = i_cmd_valid && o_cmd_ready;
   wire in_sem    = (i_cmd.op == DPRAA_OP_SEM_READ) || (i_cmd.op == DPRAA_OP_SEM_WRITE);
   wire in_write  = (i_cmd.op == DPRAA_OP_MEM_WRITE) || (i_cmd.op == DPRAA_OP_SEM_WRITE);
   wire is_write  = (cmd.op == DPRAA_OP_MEM_WRITE) || (cmd.op == DPRAA_OP_SEM_WRITE);
   wire act_write = (state == ST_IDLE) ? in_write : is_write;
   wire cnt_done  = (cnt == CNT_ZERO);
   wire logic [CNT_W-1:0] cnt_dec = cnt_done ? CNT_ZERO : CNT_W'(cnt - CNT_ONE);
   wire drive_on  = (next_state == ST_SETUP) || (next_state == ST_STROBE) || (next_state == ST_RELEASE);
   wire pins_off  = (next_state == ST_IDLE) || (next_state == ST_RECOVER);
   wire finish    = (next_state == ST_RECOVER) && (state != ST_RECOVER);

   // A semaphore cycle keeps port select high and uses the lower lane only.
   assign setup_pins = '{port_select_n:       in_sem,
                         semaphore_select_n:  !in_sem,
                         upper_lane_select_n: in_sem ? LEVEL_HI : i_cmd.upper_lane_select_n,
                         lower_lane_select_n: in_sem ? LEVEL_LO : i_cmd.lower_lane_select_n,
                         write_n:             LEVEL_HI,
                         output_enable_n:     in_write,
                         addr:                i_cmd.addr};

   // Selects settle one cycle before the strobe falls, so the device never floats write data.
   assign next_pins = pins_off ? PINS_IDLE :
                      (state == ST_IDLE) ? setup_pins :
                      '{port_select_n:       o_pins.port_select_n,
                        semaphore_select_n:  o_pins.semaphore_select_n,
                        upper_lane_select_n: o_pins.upper_lane_select_n,
                        lower_lane_select_n: o_pins.lower_lane_select_n,
                        write_n:             (next_state != ST_STROBE),
                        output_enable_n:     o_pins.output_enable_n,
                        addr:                o_pins.addr};

   // ==========================================================================
   // Sequencer
   always_comb begin
      next_state = state;
      next_cnt   = cnt_dec;
      unique case (state)
         ST_IDLE: begin
            if (take) begin
               next_state = ST_SETUP;
            end
         end
         ST_SETUP: begin
            if (!is_write) begin
               next_state = ST_READ_WAIT;
               next_cnt   = CNT_W'(READ_CYC - CNT_ONE);
            end else if (busy_n_s) begin
               next_state = ST_STROBE;
               next_cnt   = CNT_W'(PWE_CYC - CNT_ONE);
            end
         end
         ST_STROBE: begin
            if (!busy_n_s) begin
               next_state = ST_SETUP;
            end else if (cnt_done) begin
               next_state = ST_RELEASE;
            end
         end
         ST_RELEASE: begin
            next_state = ST_RECOVER;
            next_cnt   = CNT_W'(SOP_CYC - CNT_ONE);
         end
         ST_READ_WAIT: begin
            // Data are only valid once busy has gone high again.
            if (!busy_n_s) begin
               next_cnt = CNT_W'(READ_CYC - CNT_ONE);
            end else if (cnt_done) begin
               next_state = ST_RECOVER;
               next_cnt   = CNT_W'(SOP_CYC - CNT_ONE);
            end
         end
         ST_RECOVER: begin
            if (cnt_done) begin
               next_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= ST_IDLE;
         cnt   <= CNT_ZERO;
         cmd   <= '0;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
         cmd   <= take ? i_cmd : cmd;
      end
   end

   // ==========================================================================
   // Output registers
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_pins      <= PINS_IDLE;
         o_data      <= '0;
         o_data_oe   <= LEVEL_LO;
         o_cmd_ready <= LEVEL_LO;
         o_rsp_valid <= LEVEL_LO;
         o_rsp_data  <= '0;
      end else begin
         o_pins      <= next_pins;
         o_data      <= take ? i_cmd.wdata : o_data;
         o_data_oe   <= act_write && drive_on;
         o_cmd_ready <= (next_state == ST_IDLE);
         o_rsp_valid <= finish;
         o_rsp_data  <= (finish && !is_write) ? rdata_s : o_rsp_data;
      end
   end

   // ==========================================================================
   // Checks
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_arst_n);

   a_read_strobe_high: assert property (!o_pins.output_enable_n |-> o_pins.write_n)
      else $error("Write strobe low during a read cycle.");
   a_addr_strobe_high: assert property ($changed(o_pins.addr) |-> o_pins.write_n && $past(o_pins.write_n))
      else $error("Address changed while the write strobe was low.");
   a_write_overlap: assert property (!o_pins.write_n |->
      (!o_pins.port_select_n || !o_pins.semaphore_select_n) && o_data_oe &&
      (!o_pins.upper_lane_select_n || !o_pins.lower_lane_select_n))
      else $error("Write strobe low without select and lane overlap.");
   a_ram_select_mode: assert property (!o_pins.port_select_n |-> o_pins.semaphore_select_n)
      else $error("Port select and semaphore select both low.");
   a_sem_port_high: assert property (!o_pins.semaphore_select_n |->
      o_pins.port_select_n && $past(o_pins.port_select_n))
      else $error("Port select fell during a semaphore access.");
   a_sem_access_hold: assert property (!o_pins.semaphore_select_n && !o_pins.write_n |->
      o_pins.port_select_n && !o_pins.lower_lane_select_n)
      else $error("Semaphore write without port select high.");
   a_sem_request_bit: assert property (!o_pins.semaphore_select_n && !o_pins.write_n |->
      o_data[SEM_BIT] == cmd.wdata[SEM_BIT] && o_data_oe)
      else $error("Semaphore write does not carry the requested bit.");
   a_busy_strobe_off: assert property (!busy_n_s |=> o_pins.write_n)
      else $error("Write strobe stayed low after busy was seen.");
   a_strobe_width: assert property ($fell(o_pins.write_n) && busy_n_s |->
      !o_pins.write_n ##1 (!o_pins.write_n || !$past(busy_n_s)))
      else $error("Write pulse shorter than the least width.");
   a_select_first: assert property ($fell(o_pins.write_n) |->
      $past(!o_pins.port_select_n || !o_pins.semaphore_select_n))
      else $error("Select did not lead the write strobe.");
   a_cmd_answered: assert property (take |-> ##[3:40] o_rsp_valid)
      else $error("Request not answered in time.");

   c_mem_write: cover property (take && i_cmd.op == DPRAA_OP_MEM_WRITE ##[1:20] o_rsp_valid);
   c_mem_read: cover property (take && i_cmd.op == DPRAA_OP_MEM_READ ##[1:20] o_rsp_valid);
   c_sem_request: cover property (!o_pins.semaphore_select_n && !o_pins.write_n && !o_data[SEM_BIT]);
   c_busy_retry: cover property (state == ST_STROBE && !busy_n_s);

endmodule : dpraa_host

`default_nettype wire

// *** tb/dpraa_dev_model.sv ***
// Behavioural model of the dual-port memory as seen from the port that the host drives.
`default_nettype none

module dpraa_dev_model
   import dpraa_pkg::*;
(
   input  wire dpraa_pins_type i_pins,
   input  wire logic [15:0]    i_data,
   input  wire logic [7:0]     i_far_own,
   input  wire logic [13:0]    i_far_addr,
   input  wire logic           i_far_on,
   output var  logic [15:0]    o_data,
   output var  logic           o_drive,
   output var  logic           o_busy_n
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================================
   // Storage and semaphore state
   logic [15:0] mem [0:16383];
   logic [7:0]  own  = 8'h00;
   logic [15:0] last = 16'h0000;
   wire logic       ram_sel = !i_pins.port_select_n && i_pins.semaphore_select_n;
   wire logic       sem_sel = i_pins.port_select_n && !i_pins.semaphore_select_n;
   wire logic [2:0] sidx    = i_pins.addr[2:0];
   wire logic       rd      = (ram_sel || sem_sel) && !i_pins.output_enable_n && i_pins.write_n;
   wire logic [15:0] rval   = sem_sel ? {15'h7FFF, !own[sidx]} : mem[i_pins.addr];
   wire logic       wr_on   = (ram_sel || sem_sel) && !i_pins.write_n;

   // The far port is taken to have won the priority race, so busy only ever goes to this side.
   assign o_busy_n = !(i_far_on && ram_sel && (i_pins.addr == i_far_addr));

   initial begin
      for (int i = 0; i < 16384; i++) mem[i] = 16'h0000;
   end

   // ==========================================================================
   // Writes land at the end of the overlap; a write made while busy is low is dropped.
   always @(negedge wr_on) begin
      if (ram_sel && o_busy_n && !i_pins.upper_lane_select_n) mem[i_pins.addr][15:8] = i_data[15:8];
      if (ram_sel && o_busy_n && !i_pins.lower_lane_select_n) mem[i_pins.addr][7:0] = i_data[7:0];
      if (sem_sel && !i_pins.lower_lane_select_n) begin
         if (!i_data[0] && !i_far_own[sidx]) own[sidx] = 1'b1;
         else if (i_data[0]) own[sidx] = 1'b0;
      end
   end

   // ==========================================================================
   // A released bus shows the inverse of the last value, never a stale copy.
   always @(rval or rd) begin
      if (rd) last = rval;
   end
   assign o_drive = rd;
   assign o_data  = rd ? rval : ~last;

endmodule : dpraa_dev_model

`default_nettype wire

// *** tb/tb_dual_port_ram_access_arbiter.sv ***
// Self-checking testbench for the dual-port memory host controller.
`default_nettype none

module tb_dual_port_ram_access_arbiter
   import dpraa_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================================
   // Signals
   typedef struct packed {
      dpraa_op_type op;
      logic [13:0]  a;
      logic [15:0]  d;
      logic [1:0]   ln;
      logic [15:0]  x;
   } dpraa_row_type;

   localparam dpraa_row_type ROWS [10] = '{
      '{DPRAA_OP_MEM_WRITE, 14'h0010, 16'hA5C3, 2'h0, 16'h0000},
      '{DPRAA_OP_MEM_READ,  14'h0010, 16'h0000, 2'h0, 16'hA5C3},
      '{DPRAA_OP_MEM_WRITE, 14'h0010, 16'h1234, 2'h1, 16'h0000},
      '{DPRAA_OP_MEM_READ,  14'h0010, 16'h0000, 2'h0, 16'h12C3},
      '{DPRAA_OP_MEM_WRITE, 14'h0011, 16'hBEEF, 2'h2, 16'h0000},
      '{DPRAA_OP_MEM_READ,  14'h0011, 16'h0000, 2'h0, 16'h00EF},
      '{DPRAA_OP_SEM_WRITE, 14'h0003, 16'h0000, 2'h2, 16'h0000},
      '{DPRAA_OP_SEM_READ,  14'h0003, 16'h0000, 2'h2, 16'hFFFE},
      '{DPRAA_OP_SEM_WRITE, 14'h0003, 16'h0001, 2'h2, 16'h0000},
      '{DPRAA_OP_SEM_READ,  14'h0003, 16'h0000, 2'h2, 16'hFFFF}
   };

   logic           clk     = 1'b0;
   logic           arst_n  = 1'b0;
   logic           valid   = 1'b0;
   logic [7:0]     far_own = 8'h00;
   logic [13:0]    far_addr = 14'h0000;
   logic           far_on  = 1'b0;
   logic           busy_n;
   dpraa_cmd_type  cmd     = '0;
   logic           ready, rsp_v, oe, dev_drv, ok;
   logic [15:0]    rsp_d, dout, dev_d, bus;
   dpraa_pins_type pins, pins_q;
   int             error_cnt = 0;
   int             total_checks = 0;
   int             bcnt = 0;

   always #4 clk = ~clk;
   assign bus = oe ? dout : dev_d;

   dpraa_host dut (.i_ref_clk(clk), .i_arst_n(arst_n), .i_cmd_valid(valid), .i_cmd(cmd), .o_cmd_ready(ready),
      .o_rsp_valid(rsp_v), .o_rsp_data(rsp_d), .o_pins(pins), .i_data(bus), .o_data(dout), .o_data_oe(oe),
      .i_busy_n(busy_n));
   dpraa_dev_model dev (.i_pins(pins), .i_data(bus), .i_far_own(far_own), .i_far_addr(far_addr), .i_far_on(far_on),
      .o_data(dev_d), .o_drive(dev_drv), .o_busy_n(busy_n));

   // ==========================================================================
   // Compare and transfer tasks
   task automatic fail(string what, logic [15:0] e, logic [15:0] s);
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, e, s);
   endtask : fail

   task automatic check16(string what, logic [15:0] e, logic [15:0] s);
      total_checks++;
      if (s !== e) fail(what, e, s);
   endtask : check16

   task automatic check1(string what, logic e, logic s);
      total_checks++;
      if (s !== e) fail(what, {15'h0, e}, {15'h0, s});
   endtask : check1

   task automatic send(dpraa_row_type r);
      for (int i = 0; i < 50 && ready !== 1'b1; i++) @(negedge clk);
      @(posedge clk);
      valid <= 1'b1;
      cmd   <= '{op: r.op, addr: r.a, wdata: r.d, upper_lane_select_n: r.ln[1], lower_lane_select_n: r.ln[0]};
      @(posedge clk);
      valid <= 1'b0;
   endtask : send

   task automatic await(int n);
      ok = 1'b0;
      for (int i = 0; i < n && !ok; i++) begin
         @(negedge clk);
         ok = (rsp_v === 1'b1);
      end
   endtask : await

   task automatic op(dpraa_row_type r);
      send(r);
      await(60);
      check1("response", 1'b1, ok);
      if (r.op inside {DPRAA_OP_MEM_READ, DPRAA_OP_SEM_READ}) check16("read data", r.x, rsp_d);
   endtask : op

   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : test_done

   // ==========================================================================
   // Pin monitor; busy is given four cycles because it crosses the two-flop synchroniser first.
   always @(posedge clk) begin
      pins_q <= pins;
      bcnt   <= busy_n ? 0 : bcnt + 1;
      if (arst_n) begin
         if (!pins.semaphore_select_n && pins.port_select_n !== 1'b1) fail("port select", 16'h0001, 16'h0000);
         if (pins.write_n !== 1'b1 && pins.output_enable_n !== 1'b1) fail("output enable", 16'h0001, 16'h0000);
         if (pins.addr !== pins_q.addr && (pins.write_n !== 1'b1 || pins_q.write_n !== 1'b1))
            fail("strobe at address change", 16'h0001, 16'h0000);
         if (bcnt > 3 && pins.write_n !== 1'b1) fail("strobe under busy", 16'h0001, 16'h0000);
         if (oe === 1'b1 && dev_drv === 1'b1) fail("bus contention", 16'h0000, 16'h0001);
      end
   end

   initial begin
      #20000;
      error_cnt++;
      test_done();
   end

   // ==========================================================================
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      check1("ready in reset", 1'b0, ready);
      check1("pins idle in reset", 1'b1, pins === PINS_IDLE);
      arst_n <= 1'b1;
      for (int i = 0; i < 10; i++) op(ROWS[i]);
      $display("test table done");
      far_own <= 8'h20;
      op('{DPRAA_OP_SEM_WRITE, 14'h0005, 16'h0000, 2'h2, 16'h0000});
      op('{DPRAA_OP_SEM_READ, 14'h0005, 16'h0000, 2'h2, 16'hFFFF});
      far_own <= 8'h00;
      op('{DPRAA_OP_SEM_WRITE, 14'h0005, 16'h0000, 2'h2, 16'h0000});
      op('{DPRAA_OP_SEM_READ, 14'h0005, 16'h0000, 2'h2, 16'hFFFE});
      $display("test semaphore done");
      @(posedge clk);
      far_addr <= 14'h0020;
      far_on   <= 1'b1;
      send('{DPRAA_OP_MEM_WRITE, 14'h0020, 16'h5555, 2'h0, 16'h0000});
      await(20);
      check1("response under busy", 1'b0, ok);
      check1("busy on address match", 1'b0, busy_n);
      @(posedge clk);
      far_on <= 1'b0;
      await(60);
      check1("response after busy", 1'b1, ok);
      op('{DPRAA_OP_MEM_READ, 14'h0020, 16'h0000, 2'h0, 16'h5555});
      $display("test busy done");
      test_done();
   end

endmodule : tb_dual_port_ram_access_arbiter

`default_nettype wire
